// [dpscs_slave.sv]
// Two-wire command slave for a dual digitally controlled potentiometer
`timescale 1ns/1ps
`include "dpscs_regs.svh"

module dpscs_slave #(
	parameter logic [3:0] DEV_TYPE = 4'hA, // Device type code, value arbitrary
	parameter int NV_CYC = `DPSCS_NV_WRITE_US * `DPSCS_CLK_MHZ // Write cycle length
) (
	input wire logic core_clk_in, // Core clock, 250 MHz
	input wire logic rst_in, // Asynchronous reset, active high
	input wire logic scl_in, // Serial clock from the master
	input wire logic sda_in, // Serial data line level
	output logic sda_out, // Serial data drive level, always low
	output logic sda_oe_out, // High while pulling the data line low
	input wire logic [3:0] addr_strap_in, // Address strap inputs
	input wire logic wp_n_in, // Write protect, active low
	output logic [1:0][7:0] wiper_position_out, // Wiper positions per pot
	output logic [1:0][255:0] tap_sel_out, // One-hot tap switch enables per pot
	output logic nv_busy_out // Nonvolatile write in progress
);
	localparam int NV_MAX_CYC = `DPSCS_NV_WRITE_MAX_US * `DPSCS_CLK_MHZ;

	dpscs_pkg::dpscs_link_s lk_r_q;
	dpscs_pkg::dpscs_link_s lk_r_d;
	logic lk_f_q;
	dpscs_pkg::dpscs_core_s q;
	dpscs_pkg::dpscs_core_s n;
	logic start_ev;
	logic stop_ev;
	logic rise_ev;
	logic fall_ev;
	logic din;
	logic [7:0] nb;

	function automatic logic instr_ok(input dpscs_pkg::dpscs_byte_t b);
		logic [3:0] op;
		logic zsel;
		op = b[`DPSCS_OPC_MSB:`DPSCS_OPC_LSB];
		zsel = b[`DPSCS_SETTING_SELECT_HIGH_BIT] | b[`DPSCS_SETTING_SELECT_LOW_BIT];
		instr_ok = 1'b0;
		if (!b[`DPSCS_ZERO_BIT]) begin
			case (op)
				`DPSCS_OP_RD_WIPER, `DPSCS_OP_WR_WIPER, `DPSCS_OP_STEP: instr_ok = !zsel;
				`DPSCS_OP_RD_STORED, `DPSCS_OP_WR_STORED: instr_ok = 1'b1;
				`DPSCS_OP_COPY_TO_WIPER, `DPSCS_OP_COPY_TO_STORED: instr_ok = 1'b1;
				`DPSCS_OP_ALL_TO_WIPER, `DPSCS_OP_ALL_TO_STORED: begin
					instr_ok = !b[`DPSCS_POT_SELECT_BIT];
				end
				default: instr_ok = 1'b0;
			endcase
		end
	endfunction

	function automatic logic [1:0] sel_of(input dpscs_pkg::dpscs_byte_t b);
		sel_of = {b[`DPSCS_SETTING_SELECT_HIGH_BIT], b[`DPSCS_SETTING_SELECT_LOW_BIT]};
	endfunction

	function automatic logic [7:0] sat_step(input logic [7:0] w, input logic up);
		if (up) begin
			sat_step = (w == 8'hFF) ? w : w + 8'h01;
		end else begin
			sat_step = (w == 8'h00) ? w : w - 8'h01;
		end
	endfunction

	// Link side: sample data on each rising serial clock, flag each edge by toggling
	always_comb begin
		lk_r_d = lk_r_q;
		lk_r_d.tog = ~lk_r_q.tog;
		lk_r_d.smp = sda_in;
	end

	always_ff @(posedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			lk_r_q <= '0;
		end else begin
			lk_r_q <= lk_r_d;
		end
	end

	// Falling edges travel the same path length as rising ones, so their order holds
	always_ff @(negedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			lk_f_q <= 1'b0;
		end else begin
			lk_f_q <= ~lk_f_q;
		end
	end

	assign start_ev = q.scl_sy[1] & q.sda_p & ~q.sda_sy[1];
	assign stop_ev = q.scl_sy[1] & ~q.sda_p & q.sda_sy[1];
	assign rise_ev = q.rise_sy[2] ^ q.rise_sy[3];
	assign fall_ev = q.fall_sy[2] ^ q.fall_sy[3];
	assign din = q.smp_sy[1];
	assign nb = {q.shreg[6:0], din};

	always_comb begin
		logic pot;
		logic [1:0] sel;
		logic [3:0] op;
		n = q;
		pot = q.instr[`DPSCS_POT_SELECT_BIT];
		sel = sel_of(q.instr);
		op = q.instr[`DPSCS_OPC_MSB:`DPSCS_OPC_LSB];
		n.scl_sy = {q.scl_sy[0], scl_in};
		n.sda_sy = {q.sda_sy[0], sda_in};
		n.sda_p = q.sda_sy[1];
		n.rise_sy = {q.rise_sy[2:0], lk_r_q.tog};
		n.fall_sy = {q.fall_sy[2:0], lk_f_q};
		n.smp_sy = {q.smp_sy[0], lk_r_q.smp};
		n.wp_sy = {q.wp_sy[0], wp_n_in};
		n.strap_sy = {q.strap_sy[0], addr_strap_in};
		n.sda_lvl = 1'b0;
		for (int p = 0; p < 2; p++) begin
			n.tap[p] = `DPSCS_TAP_RST << q.wiper[p];
		end
		if (q.busy) begin
			if (q.busy_cnt == 32'(NV_CYC - 1)) begin
				n.busy = 1'b0;
			end else begin
				n.busy_cnt = q.busy_cnt + 32'h1;
			end
		end
		if (fall_ev) begin
			case (q.st)
				dpscs_pkg::ST_ACK_ID, dpscs_pkg::ST_ACK_INSTR, dpscs_pkg::ST_ACK_DATA: begin
					n.sda_oe = q.ack_ok;
				end
				dpscs_pkg::ST_TX: n.sda_oe = ~q.shreg[7];
				default: n.sda_oe = 1'b0;
			endcase
		end
		case (q.st)
			dpscs_pkg::ST_BOOT: begin
				for (int p = 0; p < 2; p++) begin
					n.wiper[p] = q.stored[p][0];
				end
				n.st = dpscs_pkg::ST_IDLE;
			end
			dpscs_pkg::ST_ID, dpscs_pkg::ST_INSTR, dpscs_pkg::ST_DATA: begin
				if (rise_ev) begin
					n.shreg = nb;
					n.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt == 4'h7) begin
						n.bitcnt = 4'h0;
						if (q.st == dpscs_pkg::ST_ID) begin
							n.st = dpscs_pkg::ST_ACK_ID;
							// type, strap match, busy withholds acknowledge
							n.ack_ok = (nb[`DPSCS_TYPE_MSB:`DPSCS_TYPE_LSB] == DEV_TYPE) &&
								(nb[`DPSCS_STRAP_MSB:`DPSCS_STRAP_LSB] == q.strap_sy[1]) &&
								!q.busy;
						end else if (q.st == dpscs_pkg::ST_INSTR) begin
							n.st = dpscs_pkg::ST_ACK_INSTR;
							n.instr = nb;
							n.ack_ok = instr_ok(nb);
						end else begin
							n.st = dpscs_pkg::ST_ACK_DATA;
							n.ack_ok = 1'b1;
						end
					end
				end
			end
			dpscs_pkg::ST_ACK_ID: begin
				if (rise_ev) begin
					n.st = q.ack_ok ? dpscs_pkg::ST_INSTR : dpscs_pkg::ST_WAIT_STOP;
				end
			end
			dpscs_pkg::ST_ACK_INSTR: begin
				if (rise_ev) begin
					n.st = dpscs_pkg::ST_WAIT_STOP;
					if (q.ack_ok) begin
						case (op)
							`DPSCS_OP_RD_WIPER: begin
								n.shreg = q.wiper[pot];
								n.st = dpscs_pkg::ST_TX;
							end
							`DPSCS_OP_RD_STORED: begin
								n.shreg = q.stored[pot][sel];
								n.st = dpscs_pkg::ST_TX;
							end
							`DPSCS_OP_WR_WIPER, `DPSCS_OP_WR_STORED: begin
								n.st = dpscs_pkg::ST_DATA;
							end
							`DPSCS_OP_COPY_TO_WIPER: n.wiper[pot] = q.stored[pot][sel];
							`DPSCS_OP_COPY_TO_STORED: begin
								n.nv_pend = 1'b1;
								n.nv_mask = 2'b01 << pot;
								n.nv_sel = sel;
								n.nv_data[pot] = q.wiper[pot];
							end
							`DPSCS_OP_ALL_TO_WIPER: begin
								for (int p = 0; p < 2; p++) begin
									n.wiper[p] = q.stored[p][sel];
								end
							end
							`DPSCS_OP_ALL_TO_STORED: begin
								n.nv_pend = 1'b1;
								n.nv_mask = 2'b11;
								n.nv_sel = sel;
								n.nv_data = q.wiper;
							end
							`DPSCS_OP_STEP: n.st = dpscs_pkg::ST_STEP;
							default: n.st = dpscs_pkg::ST_WAIT_STOP;
						endcase
					end
				end
			end
			dpscs_pkg::ST_ACK_DATA: begin
				if (rise_ev) begin
					n.st = dpscs_pkg::ST_WAIT_STOP;
					if (op == `DPSCS_OP_WR_WIPER) begin
						n.wiper[pot] = q.shreg;
					end else begin
						// write stored setting waits for stop
						n.nv_pend = 1'b1;
						n.nv_mask = 2'b01 << pot;
						n.nv_sel = sel;
						n.nv_data[pot] = q.shreg;
					end
				end
			end
			dpscs_pkg::ST_TX: begin
				if (rise_ev) begin
					n.shreg = {q.shreg[6:0], 1'b0};
					n.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt == 4'h7) begin
						n.bitcnt = 4'h0;
						n.st = dpscs_pkg::ST_TX_ACK;
					end
				end
			end
			dpscs_pkg::ST_TX_ACK: begin
				// Only one byte is returned whatever the master answers
				if (rise_ev) begin
					n.st = dpscs_pkg::ST_WAIT_STOP;
				end
			end
			dpscs_pkg::ST_STEP: begin
				if (rise_ev) begin
					n.wiper[pot] = sat_step(q.wiper[pot], din);
				end
			end
			dpscs_pkg::ST_IDLE, dpscs_pkg::ST_WAIT_STOP: n.st = q.st;
			default: n.st = dpscs_pkg::ST_IDLE;
		endcase
		if (q.st != dpscs_pkg::ST_BOOT) begin
			if (start_ev) begin
				n.st = dpscs_pkg::ST_ID;
				n.bitcnt = 4'h0;
				n.sda_oe = 1'b0;
				n.nv_pend = 1'b0;
			end else if (stop_ev) begin
				n.st = dpscs_pkg::ST_IDLE;
				n.sda_oe = 1'b0;
				n.nv_pend = 1'b0;
				// launch write on stop, write protect blocks it
				if (q.nv_pend && q.wp_sy[1]) begin
					for (int p = 0; p < 2; p++) begin
						if (q.nv_mask[p]) begin
							n.stored[p][q.nv_sel] = q.nv_data[p];
						end
					end
					n.busy = 1'b1;
					n.busy_cnt = 32'h0;
				end
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			q <= '0;
			q.st <= dpscs_pkg::ST_BOOT;
			q.stored <= {8{`DPSCS_STORED_RST}};
			q.wiper <= {2{`DPSCS_WIPER_RST}};
			q.tap <= {2{`DPSCS_TAP_RST}};
			// Idle lines are high; a low reset value would fake a stop after release
			q.scl_sy <= 2'b11;
			q.sda_sy <= 2'b11;
			q.sda_p <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign sda_out = q.sda_lvl;
	assign sda_oe_out = q.sda_oe;
	assign wiper_position_out = q.wiper;
	assign tap_sel_out = q.tap;
	assign nv_busy_out = q.busy;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	property p_idle_quiet;
		q.st == dpscs_pkg::ST_IDLE && !start_ev |=> q.st == dpscs_pkg::ST_IDLE && !q.sda_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("left idle without start");

	property p_start;
		start_ev && q.st != dpscs_pkg::ST_BOOT |=> q.st == dpscs_pkg::ST_ID && q.bitcnt == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_stop;
		stop_ev && !start_ev && q.st != dpscs_pkg::ST_BOOT |=>
			q.st == dpscs_pkg::ST_IDLE && !q.sda_oe && !q.nv_pend;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end transaction");

	property p_ack_drive;
		q.st == dpscs_pkg::ST_ACK_INSTR && q.ack_ok && fall_ev && !start_ev && !stop_ev
			|=> q.sda_oe;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

	property p_tx_release;
		q.st == dpscs_pkg::ST_TX_ACK && fall_ev |=> !q.sda_oe;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("line held after byte");

	property p_addr_ack;
		q.st == dpscs_pkg::ST_ID && rise_ev && q.bitcnt == 4'h7 && !start_ev && !stop_ev &&
			nb[7:4] == DEV_TYPE && nb[3:0] == q.strap_sy[1] && !q.busy
			|=> q.st == dpscs_pkg::ST_ACK_ID && q.ack_ok;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");

	property p_busy_nack;
		q.busy && q.st == dpscs_pkg::ST_ID && rise_ev && q.bitcnt == 4'h7 |=> !q.ack_ok;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

	property p_nv_launch;
		stop_ev && !start_ev && q.nv_pend && q.wp_sy[1] && q.st != dpscs_pkg::ST_BOOT
			|=> q.busy && q.busy_cnt == 32'h0 ##1 q.busy;
	endproperty
	a_nv_launch: assert property (p_nv_launch) else $error("write cycle not launched");

	property p_wp_block;
		stop_ev && q.nv_pend && !q.wp_sy[1] && !q.busy |=> $stable(q.stored) && !q.busy;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write happened");

	property p_nv_bound;
		q.busy |-> q.busy_cnt < 32'(NV_MAX_CYC);
	endproperty
	a_nv_bound: assert property (p_nv_bound) else $error("write cycle too long");

	property p_step_sat;
		q.st == dpscs_pkg::ST_STEP && rise_ev && din &&
			q.wiper[q.instr[0]] == 8'hFF |=> q.wiper[q.instr[0]] == 8'hFF;
	endproperty
	a_step_sat: assert property (p_step_sat) else $error("wiper wrapped");

	property p_boot;
		q.st == dpscs_pkg::ST_BOOT |=> q.wiper[0] == q.stored[0][0] &&
			q.wiper[1] == q.stored[1][0];
	endproperty
	a_boot: assert property (p_boot) else $error("power-up recall missing");

	property p_onehot;
		q.st != dpscs_pkg::ST_BOOT |=> $onehot(q.tap[0]) && $onehot(q.tap[1]);
	endproperty
	a_onehot: assert property (p_onehot) else $error("tap decode not one-hot");

	c_read: cover property (q.st == dpscs_pkg::ST_TX_ACK && rise_ev);
	c_nv_write: cover property (stop_ev && q.nv_pend && q.wp_sy[1]);
	c_step: cover property (q.st == dpscs_pkg::ST_STEP && rise_ev);
	c_busy_poll: cover property (q.busy && q.st == dpscs_pkg::ST_ACK_ID);
endmodule

// [dpscs_regs.svh]
// Constants of the dual potentiometer serial command slave
`ifndef DPSCS_REGS_SVH
`define DPSCS_REGS_SVH

// Identification byte fields
`define DPSCS_TYPE_MSB 7
`define DPSCS_TYPE_LSB 4
`define DPSCS_STRAP_MSB 3
`define DPSCS_STRAP_LSB 0

// Instruction byte fields
`define DPSCS_OPC_MSB 7
`define DPSCS_OPC_LSB 4
`define DPSCS_SETTING_SELECT_HIGH_BIT 3
`define DPSCS_SETTING_SELECT_LOW_BIT 2
`define DPSCS_ZERO_BIT 1
`define DPSCS_POT_SELECT_BIT 0

// Opcodes
`define DPSCS_OP_RD_WIPER 4'h9
`define DPSCS_OP_WR_WIPER 4'hA
`define DPSCS_OP_RD_STORED 4'hB
`define DPSCS_OP_WR_STORED 4'hC
`define DPSCS_OP_COPY_TO_WIPER 4'hD
`define DPSCS_OP_COPY_TO_STORED 4'hE
`define DPSCS_OP_ALL_TO_WIPER 4'h1
`define DPSCS_OP_ALL_TO_STORED 4'h8
`define DPSCS_OP_STEP 4'h2

// Reset values
`define DPSCS_STORED_RST 8'h80
`define DPSCS_WIPER_RST 8'h00
`define DPSCS_TAP_RST 256'h1

// Timing
`define DPSCS_CLK_MHZ 250
`define DPSCS_NV_WRITE_US 5000
`define DPSCS_NV_WRITE_MAX_US 10000

`endif

// [dpscs_pkg.sv]
// Types of the dual potentiometer serial command slave
package dpscs_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ID = 4'h1,
		ST_ACK_ID = 4'h2,
		ST_INSTR = 4'h3,
		ST_ACK_INSTR = 4'h4,
		ST_DATA = 4'h5,
		ST_ACK_DATA = 4'h6,
		ST_TX = 4'h7,
		ST_TX_ACK = 4'h8,
		ST_STEP = 4'h9,
		ST_WAIT_STOP = 4'hA,
		ST_BOOT = 4'hB
	} dpscs_state_e;

	typedef logic [7:0] dpscs_byte_t;

	typedef struct packed {
		logic tog;
		logic smp;
	} dpscs_link_s;

	typedef struct packed {
		dpscs_state_e st;
		logic [3:0] bitcnt;
		dpscs_byte_t shreg;
		dpscs_byte_t instr;
		logic ack_ok;
		logic [1:0] scl_sy;
		logic [1:0] sda_sy;
		logic sda_p;
		logic [3:0] rise_sy;
		logic [3:0] fall_sy;
		logic [1:0] smp_sy;
		logic [1:0] wp_sy;
		logic [1:0][3:0] strap_sy;
		logic nv_pend;
		logic [1:0] nv_mask;
		logic [1:0] nv_sel;
		logic [1:0][7:0] nv_data;
		logic busy;
		logic [31:0] busy_cnt;
		logic sda_oe;
		logic sda_lvl;
		logic [1:0][7:0] wiper;
		logic [1:0][3:0][7:0] stored;
		logic [1:0][255:0] tap;
	} dpscs_core_s;
endpackage

// [dpscs_master_model.sv]
// Bus master model for the two-wire link of the potentiometer slave
`timescale 1ns/1ps
module dpscs_master_model (
	input wire logic sda_in, // Resolved data line
	output logic scl_out, // Serial clock, idles high
	output logic sda_out // Data drive, high releases the line
);
	logic link_clk;
	initial begin
		link_clk = 1'b0;
		scl_out = 1'b1;
		sda_out = 1'b1;
		forever #7.5 link_clk = ~link_clk;
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge link_clk);
	endtask
	task automatic start();
		sda_out <= 1'b1;
		ticks(2);
		scl_out <= 1'b1;
		ticks(3);
		sda_out <= 1'b0;
		ticks(3);
		scl_out <= 1'b0;
		ticks(2);
	endtask
	task automatic stop();
		sda_out <= 1'b0;
		ticks(2);
		scl_out <= 1'b1;
		ticks(3);
		sda_out <= 1'b1;
		ticks(4);
	endtask
	// data moves only while the clock is low
	task automatic bit_cyc(input logic b, output logic r);
		sda_out <= b;
		ticks(3);
		scl_out <= 1'b1;
		ticks(3);
		r = sda_in;
		scl_out <= 1'b0;
		ticks(1);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], r);
		end
		bit_cyc(1'b1, r);
		ack = ~r;
	endtask
	// Single-byte reads always end with a not-acknowledge
	task automatic rbyte(output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b1, b[i]);
		end
		bit_cyc(1'b1, r);
	endtask
	task automatic step(input logic up);
		logic r;
		bit_cyc(up, r);
	endtask
endmodule

// [dpscs_slave_tb.sv]
// Self-checking bench of the potentiometer command slave
`timescale 1ns/1ps
module dpscs_slave_tb;
	localparam int NV = 2000;
	logic core_clk_in;
	logic rst_in;
	logic wp_n_in;
	logic scl;
	logic sda_drv;
	logic sda_line;
	logic sda_oe;
	logic sda_lvl;
	logic busy;
	logic [3:0] strap;
	logic [1:0][7:0] wiper;
	logic [1:0][255:0] tap;
	logic [7:0] exp_st [2][4];
	logic [7:0] exp_wp [2];
	logic [15:0] exp_q [$];
	logic [15:0] obs_q [$];
	logic [7:0] id_b;
	int n_mismatch = 0;
	int check_count = 0;
	// Open drain: the pull-up wins unless someone pulls low
	assign sda_line = sda_drv & ~(sda_oe & ~sda_lvl);
	dpscs_slave #(.NV_CYC(NV)) dut (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_out(sda_lvl),
		.sda_oe_out(sda_oe),
		.addr_strap_in(strap),
		.wp_n_in(wp_n_in),
		.wiper_position_out(wiper),
		.tap_sel_out(tap),
		.nv_busy_out(busy)
	);
	dpscs_master_model m (.sda_in(sda_line), .scl_out(scl), .sda_out(sda_drv));
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic note(input logic [15:0] e, input logic [15:0] o);
		exp_q.push_back(e);
		obs_q.push_back(o);
	endtask
	initial forever begin
		@(posedge core_clk_in);
		while (obs_q.size() > 0) begin
			check_count++;
			if (obs_q[0] !== exp_q[0]) begin
				n_mismatch++;
				$display("MISMATCH t=%0t exp=%h got=%h", $time, exp_q[0], obs_q[0]);
			end
			void'(obs_q.pop_front());
			void'(exp_q.pop_front());
		end
	end
	task automatic summarize();
		repeat (2) @(posedge core_clk_in);
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// nd: 0 no data, 1 write data, 2 read data
	task automatic xfer(input logic [7:0] ins, input int nd, input logic [7:0] d,
			output logic [7:0] rd);
		logic a;
		rd = 8'h00;
		m.start();
		m.wbyte(id_b, a);
		note(16'h1, 16'(a));
		m.wbyte(ins, a);
		note(16'h1, 16'(a));
		if (nd == 1) begin
			m.wbyte(d, a);
			note(16'h1, 16'(a));
		end
		if (nd == 2)
			m.rbyte(rd);
		m.stop();
		repeat (4) @(posedge core_clk_in);
	endtask
	task automatic chk_wipers();
		for (int p = 0; p < 2; p++) begin
			note(16'(exp_wp[p]), 16'(wiper[p]));
			note(16'h1, 16'(tap[p] === (256'h1 << exp_wp[p])));
		end
	endtask
	task automatic nv_wait();
		logic a;
		int n;
		m.start();
		m.wbyte(id_b, a);
		m.stop();
		note(16'h0, 16'(a));
		note(16'h1, 16'(busy));
		n = 0;
		while (!a && n < 100) begin
			m.start();
			m.wbyte(id_b, a);
			m.stop();
			n++;
		end
		note(16'h1, 16'(a));
	endtask
	initial begin
		#400000;
		n_mismatch++;
		summarize();
	end
	initial begin
		logic a;
		logic p;
		logic [7:0] d;
		logic [7:0] r;
		rst_in = 1'b1;
		wp_n_in = 1'b1;
		strap = 4'h0;
		for (int i = 0; i < 8; i++) begin
			exp_st[i / 4][i % 4] = `DPSCS_STORED_RST;
		end
		d = 8'($urandom(32'hB9D1));
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		strap <= 4'($urandom());
		repeat (8) @(posedge core_clk_in);
		id_b = {4'hA, strap};
		exp_wp[0] = `DPSCS_STORED_RST;
		exp_wp[1] = `DPSCS_STORED_RST;
		chk_wipers();
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			m.start();
			m.wbyte(i == 0 ? {4'h3, strap} : (i == 1 ? {4'hA, ~strap} : id_b), a);
			if (i == 2) begin
				m.wbyte(8'hA2, a);
			end
			m.stop();
			note(16'h0, 16'(a));
		end
		$display("test refuse done");
		for (int i = 0; i < 2; i++) begin
			p = 1'(i);
			d = 8'($urandom());
			xfer({4'hA, 3'b000, p}, 1, d, r);
			exp_wp[i] = d;
			xfer({4'h9, 3'b000, p}, 2, 8'h00, r);
			note(16'(d), 16'(r));
		end
		chk_wipers();
		$display("test wiper done");
		for (int s = 0; s < 4; s++) begin
			p = 1'(s);
			d = 8'($urandom());
			xfer({4'hC, 2'(s), 1'b0, p}, 1, d, r);
			nv_wait();
			exp_st[p][s] = d;
			xfer({4'hB, 2'(s), 1'b0, p}, 2, 8'h00, r);
			note(16'(d), 16'(r));
			xfer({4'hD, 2'(s), 1'b0, p}, 0, 8'h00, r);
			exp_wp[p] = d;
			chk_wipers();
		end
		$display("test stored done");
		xfer(8'hE9, 0, 8'h00, r);
		nv_wait();
		exp_st[1][2] = exp_wp[1];
		xfer(8'hB9, 2, 8'h00, r);
		note(16'(exp_st[1][2]), 16'(r));
		xfer(8'h8C, 0, 8'h00, r);
		nv_wait();
		for (int i = 0; i < 2; i++) begin
			exp_st[i][3] = exp_wp[i];
			xfer({7'b1011110, 1'(i)}, 2, 8'h00, r);
			note(16'(exp_st[i][3]), 16'(r));
		end
		$display("test copy done");
		// Frame ends make one extra clock, so each case ends in saturation
		for (int i = 0; i < 2; i++) begin
			p = 1'(i);
			xfer({4'hA, 3'b000, p}, 1, p ? 8'hFD : 8'h01, r);
			m.start();
			m.wbyte(id_b, a);
			m.wbyte({4'h2, 3'b000, p}, a);
			note(16'h1, 16'(a));
			repeat (3) m.step(p);
			if (p)
				m.start();
			m.stop();
			repeat (4) @(posedge core_clk_in);
			exp_wp[i] = p ? 8'hFF : 8'h00;
			chk_wipers();
		end
		$display("test step done");
		xfer(8'h1C, 0, 8'h00, r);
		exp_wp[0] = exp_st[0][3];
		exp_wp[1] = exp_st[1][3];
		chk_wipers();
		$display("test global load done");
		@(posedge core_clk_in);
		wp_n_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		xfer(8'hC1, 1, ~exp_st[1][0], r);
		repeat (10) @(posedge core_clk_in);
		note(16'h0, 16'(busy));
		wp_n_in <= 1'b1;
		repeat (4) @(posedge core_clk_in);
		xfer(8'hB1, 2, 8'h00, r);
		note(16'(exp_st[1][0]), 16'(r));
		$display("test protect done");
		summarize();
	end
endmodule
